// [verilog/dma_evt_pkg.sv]
// Notes on behaviour
// - every channel drives its own interrupt; seven or five channels
// - three event kinds: full transfer, half transfer, transfer error
// - each event kind has its own flag, clear bit and enable bit
// - channel interrupt asserts when any enabled event flag is set
// - peripheral request lines sharing a channel are ORed together
// - flag register sits at offset 0x00, reads zero after reset
// - channel x owns bits 4x..4x+3; bits 31:28 read zero
// - flags are read-only, set by hardware, cleared via clear register
// - transfer error sets the channel error flag
// - half of the programmed items done sets the half flag
// - finished transfer sets the full flag
// - summary flag is set while any other channel flag is set
// - five-channel instance: bits of channels 5 and 6 do nothing
// - clear register at 0x04; one clears, zero ignored; summary clears all
// - circular mode raises the full flag at every pass end
package dma_evt_pkg;

  localparam int          MAX_CHAN     = 7;
  localparam int          REQ_LINES    = 4;
  localparam int          ADDR_W       = 8;

  // register offsets
  localparam logic [7:0]  OFS_FLAGS    = 8'h00;
  localparam logic [7:0]  OFS_CLEAR    = 8'h04;
  localparam logic [7:0]  OFS_ENABLE   = 8'h08;

  // field positions inside one channel nibble
  localparam int          BIT_SUM      = 0;
  localparam int          BIT_FULL     = 1;
  localparam int          BIT_HALF     = 2;
  localparam int          BIT_ERR      = 3;
  localparam int          CHAN_BITS    = 4;

  // values after reset and fixed masks
  localparam logic [31:0] RESET_FLAGS  = 32'h00000000;
  localparam logic [31:0] RESET_ENABLE = 32'h00000000;
  localparam logic [31:0] RESET_RDATA  = 32'h00000000;
  localparam logic [2:0]  RESET_EVT    = 3'h0;
  localparam logic [31:0] USED_MASK    = 32'h0FFFFFFF;
  localparam logic [31:0] ENABLE_MASK  = 32'h0EEEEEEE;
  localparam logic [27:0] RESET_REQ    = 28'h0000000;

endpackage

// [verilog/chan_evt_if.sv]
`timescale 1ns/100ps
// one channel's event slice as seen by the register block
interface chan_evt_if;
  logic       set_full;
  logic       set_half;
  logic       set_err;
  logic [3:0] clr;
  logic [2:0] en;
  logic [3:0] flags;
  logic       irq;

  modport owner (output set_full, set_half, set_err, clr, en,
                 input  flags, irq);
  modport slice (input  set_full, set_half, set_err, clr, en,
                 output flags, irq);
endinterface

// [verilog/chan_evt_slice.sv]
`timescale 1ns/100ps
module chan_evt_slice (
  input wire logic clk_sys,
  input wire logic nrst,
  chan_evt_if.slice ev
);
  import dma_evt_pkg::*;

  typedef struct packed
  {
    logic err;
    logic half;
    logic full;
  } slice_s;

  slice_s cur;
  slice_s next_cur;
  logic   wipe;

  // set beats clear so an event landing on a clear is never lost
  always_comb
  begin
    wipe          = ev.clr[BIT_SUM];
    next_cur.full = ev.set_full
                    | (cur.full & ~ev.clr[BIT_FULL] & ~wipe);
    next_cur.half = ev.set_half
                    | (cur.half & ~ev.clr[BIT_HALF] & ~wipe);
    next_cur.err  = ev.set_err
                    | (cur.err & ~ev.clr[BIT_ERR] & ~wipe);
  end

  // only events set and only clear pulses drop; software cannot set
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cur <= RESET_EVT;
    else
      cur <= next_cur;
  end

  // summary is derived, so it can never disagree with the event flags
  assign ev.flags = {cur.err, cur.half, cur.full,
                     cur.err | cur.half | cur.full};
  // level output; enable order matches {err, half, full}
  assign ev.irq   = |({cur.err, cur.half, cur.full} & ev.en);

  chk_err_set_wins: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ev.set_err |=> ev.flags[BIT_ERR])
    else $error("error event did not set the error flag");

  chk_clear_one: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ev.clr[BIT_HALF] && !ev.set_half) |=> !ev.flags[BIT_HALF])
    else $error("half clear did not drop the half flag");

  chk_summary_wipe: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ev.clr[BIT_SUM] && !ev.set_full && !ev.set_half && !ev.set_err)
      |=> (ev.flags == 4'h0))
    else $error("summary clear left a flag standing");

  chk_flag_holds: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ev.flags[BIT_FULL] && !ev.clr[BIT_FULL] && !ev.clr[BIT_SUM])
      |=> ev.flags[BIT_FULL])
    else $error("full flag dropped without a clear");

  chk_irq_follows: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ev.set_full && ev.en[0]) ##1 ev.en[0] |-> ev.irq)
    else $error("enabled full event raised no interrupt");
endmodule

// [verilog/dma_channel_event_and_request_logic.sv]
`timescale 1ns/100ps
module dma_channel_event_and_request_logic #(
  parameter int NUM_CHAN = 7
) (
  input  wire logic                                   clk_sys,
  input  wire logic                                   nrst,
  input  wire logic [dma_evt_pkg::ADDR_W-1:0]         reg_addr,
  input  wire logic [31:0]                            reg_wdata,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output      logic [31:0]                            reg_rdata,
  input  wire logic [dma_evt_pkg::MAX_CHAN-1:0]       full_evt,
  input  wire logic [dma_evt_pkg::MAX_CHAN-1:0]       half_evt,
  input  wire logic [dma_evt_pkg::MAX_CHAN-1:0]       err_evt,
  input  wire logic [dma_evt_pkg::MAX_CHAN*dma_evt_pkg::REQ_LINES-1:0]
                                                      periph_req,
  output      logic [dma_evt_pkg::MAX_CHAN-1:0]       chan_req,
  output      logic [dma_evt_pkg::MAX_CHAN-1:0]       chan_irq,
  output      logic                                   irq
);
  import dma_evt_pkg::*;

  localparam int REQ_W = MAX_CHAN * REQ_LINES;
  // channels past NUM_CHAN keep their bits dead
  localparam logic [31:0] CHAN_MASK =
    USED_MASK >> (CHAN_BITS * (MAX_CHAN - NUM_CHAN));

  typedef struct packed
  {
    logic [31:0]      enable;
    logic [31:0]      rdata;
    logic [REQ_W-1:0] req_s1;
    logic [REQ_W-1:0] req_s2;
  } top_s;

  top_s        cur;
  top_s        next_cur;
  logic [31:0] flag_vec;
  logic [31:0] clr_vec;
  logic        hit_clear;
  logic        hit_enable;

  // address decode for the write side
  assign hit_clear  = reg_wr && (reg_addr == OFS_CLEAR);
  assign hit_enable = reg_wr && (reg_addr == OFS_ENABLE);
  // write-one pulses, zero bits leave flags untouched
  assign clr_vec    = hit_clear ? (reg_wdata & CHAN_MASK) : 32'h0;

  // register file, read pipe and request synchronisers
  always_comb
  begin
    next_cur       = cur;
    next_cur.rdata = RESET_RDATA;
    if (hit_enable)
    begin
      next_cur.enable = reg_wdata & ENABLE_MASK & CHAN_MASK;
    end
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_FLAGS:  next_cur.rdata = flag_vec;
        OFS_ENABLE: next_cur.rdata = cur.enable;
        default:    next_cur.rdata = RESET_RDATA;
      endcase
    end
    // pins are asynchronous to clk_sys, hence two stages
    next_cur.req_s1 = periph_req;
    next_cur.req_s2 = cur.req_s1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cur.enable <= RESET_ENABLE;
      cur.rdata  <= RESET_RDATA;
      cur.req_s1 <= RESET_REQ;
      cur.req_s2 <= RESET_REQ;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;

  // per channel event slices and request merge
  for (genvar g = 0; g < MAX_CHAN; g++)
  begin : g_chan
    if (g < NUM_CHAN)
    begin : g_live
      chan_evt_if ev ();
      assign ev.set_full = full_evt[g];
      assign ev.set_half = half_evt[g];
      assign ev.set_err  = err_evt[g];
      assign ev.clr      = clr_vec[CHAN_BITS*g +: CHAN_BITS];
      assign ev.en       = cur.enable[CHAN_BITS*g+1 +: 3];
      assign flag_vec[CHAN_BITS*g +: CHAN_BITS] = ev.flags;
      assign chan_irq[g] = ev.irq;

      chan_evt_slice u_slice (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ev      (ev.slice)
      );
    end
    else
    begin : g_idle
      assign flag_vec[CHAN_BITS*g +: CHAN_BITS] = 4'h0;
      assign chan_irq[g] = 1'b0;
    end
    // any live shared line raises the request; several may be live at once
    assign chan_req[g] =
      |cur.req_s2[REQ_LINES*g +: REQ_LINES];
  end

  // reserved top nibble
  assign flag_vec[31:28] = 4'h0;
  // one combined line for the interrupt controller
  assign irq = |chan_irq;

  chk_read_flags: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (reg_rd && reg_addr == OFS_FLAGS) |=> reg_rdata == $past(flag_vec))
    else $error("flag read returned wrong data");

  chk_rdata_only_once: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data stood outside its cycle");

  chk_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    reg_rdata[31:28] == 4'h0)
    else $error("reserved read bits not zero");

  chk_dead_chan: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (flag_vec & ~CHAN_MASK) == 32'h0)
    else $error("unused channel shows a flag");

  chk_req_sync: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ##2 (cur.req_s2 == $past(periph_req, 2)))
    else $error("request path not two stages");

  chk_irq_any: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (err_evt[0] && cur.enable[BIT_ERR] && !hit_enable)
      |=> chan_irq[0] && irq)
    else $error("enabled error on channel 0 gave no interrupt");

  chk_irq_falls: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (hit_clear && reg_wdata[BIT_SUM] && !full_evt[0] && !half_evt[0]
      && !err_evt[0]) |=> !chan_irq[0])
    else $error("channel 0 interrupt stayed after full clear");

  chk_summary_tracks: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    flag_vec[BIT_SUM] == |flag_vec[BIT_ERR:BIT_FULL])
    else $error("summary flag disagrees with events");
endmodule

// [tb/periph_req_model.sv]
`timescale 1ns/100ps
// peripheral side: at most one request line raised at any time
module periph_req_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic [4:0]  line_sel,
  output      logic [27:0] periph_req
);
  // one-hot only, so lines sharing a channel never overlap
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      periph_req <= 28'h0000000;
    end
    else
    begin
      periph_req <= go ? (28'h0000001 << line_sel) : 28'h0000000;
    end
  end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import dma_evt_pkg::*;
  logic              clk_sys;
  logic              nrst;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic [6:0]        full_evt;
  logic [6:0]        half_evt;
  logic [6:0]        err_evt;
  logic [27:0]       periph_req;
  logic [6:0]        chan_req;
  logic [6:0]        chan_irq;
  logic              irq;
  logic              go;
  logic [4:0]        line_sel;
  logic [31:0]       rd_val;
  logic [31:0]       exp;
  int                error_cnt;
  int                n_checks;
  int                cyc;

  dma_channel_event_and_request_logic #(.NUM_CHAN(7))
    dma_channel_event_and_request_logic_inst (.clk_sys(clk_sys),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .full_evt(full_evt), .half_evt(half_evt), .err_evt(err_evt),
    .periph_req(periph_req), .chan_req(chan_req),
    .chan_irq(chan_irq), .irq(irq));
  periph_req_model periph_req_model_inst (.clk_sys(clk_sys),
    .nrst(nrst), .go(go), .line_sel(line_sel), .periph_req(periph_req));

  // 25 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // strobes last one cycle; read data only in the cycle after
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic reg_read(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  // one-cycle engine event of kind k: 0 full, 1 half, 2 error
  task automatic pulse(input int k, input logic [6:0] v);
    @(posedge clk_sys);
    full_evt <= (k == 0) ? v : 7'h00;
    half_evt <= (k == 1) ? v : 7'h00;
    err_evt  <= (k == 2) ? v : 7'h00;
    @(posedge clk_sys);
    {full_evt, half_evt, err_evt} <= 21'h000000;
    #1;
  endtask

  // hang guard, run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  initial
  begin
    {nrst, reg_wr, reg_rd, go} = 4'h0;
    {reg_addr, reg_wdata, line_sel} = 45'h0;
    {full_evt, half_evt, err_evt} = 21'h000000;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    reg_read(OFS_FLAGS);
    chk("flags", rd_val, 32'h00000000);
    reg_read(8'h0C);
    chk("unmapped", rd_val, 32'h00000000);
    reg_read(OFS_CLEAR);
    chk("clear_rd", rd_val, 32'h00000000);
    reg_write(OFS_ENABLE, ENABLE_MASK);
    reg_read(OFS_ENABLE);
    chk("enable", rd_val, 32'h0EEEEEEE);
    $display("test reset_map done");
    for (int g = 0; g < 7; g++)
      for (int k = 0; k < 3; k++)
      begin
        exp = (32'h1 << (4 * g)) | (32'h1 << (4 * g + 1 + k));
        pulse(k, 7'h01 << g);
        chk("chan_irq", {25'h0, chan_irq}, 32'h1 << g);
        chk("irq", {31'h0, irq}, 32'h1);
        reg_write(OFS_FLAGS, 32'hFFFFFFFF);
        reg_read(OFS_FLAGS);
        chk("flags", rd_val, exp);
        reg_write(OFS_CLEAR, 32'h1 << (4 * g + 1 + k));
        chk("chan_irq", {25'h0, chan_irq}, 32'h0);
        reg_read(OFS_FLAGS);
        chk("flags", rd_val, 32'h0);
      end
    $display("test event_walk done");
    // all three kinds on channel 3, then summary clear
    for (int k = 0; k < 3; k++)
      pulse(k, 7'h08);
    reg_write(OFS_CLEAR, 32'h0);
    reg_read(OFS_FLAGS);
    chk("flags", rd_val, 32'h0000F000);
    reg_write(OFS_CLEAR, 32'h00001000);
    reg_read(OFS_FLAGS);
    chk("flags", rd_val, 32'h0);
    // masked error on channel 0 keeps its flag, no interrupt
    reg_write(OFS_ENABLE, 32'h0EEEEEE6);
    pulse(2, 7'h01);
    chk("irq", {31'h0, irq}, 32'h0);
    reg_read(OFS_FLAGS);
    chk("flags", rd_val, 32'h00000009);
    // circular passes: full flag raised again after each clear
    reg_write(OFS_CLEAR, 32'h00000001);
    pulse(0, 7'h01);
    reg_write(OFS_CLEAR, 32'h00000002);
    pulse(0, 7'h01);
    reg_read(OFS_FLAGS);
    chk("flags", rd_val, 32'h00000003);
    // event and clear in one cycle: the event must survive
    @(posedge clk_sys);
    full_evt  <= 7'h02;
    reg_addr  <= OFS_CLEAR;
    reg_wdata <= 32'h00000020;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    full_evt <= 7'h00;
    reg_wr   <= 1'b0;
    reg_read(OFS_FLAGS);
    chk("flags", rd_val, 32'h00000033);
    reg_write(OFS_CLEAR, 32'h00000011);
    $display("test clear_mask done");
    for (int i = 0; i < 28; i++)
    begin
      @(posedge clk_sys);
      go       <= 1'b1;
      line_sel <= i[4:0];
      repeat (4) @(posedge clk_sys);
      #1;
      chk("chan_req", {25'h0, chan_req}, 32'h1 << (i / 4));
      go <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    $display("test requests done");
    end_sim();
  end
endmodule
